// ---- core/cise_defines.svh ----
// Constants for the instruction subset executor: cycle counts, resets, BCD correction and divide limits.
`ifndef CISE_DEFINES_SVH
`define CISE_DEFINES_SVH

// Instruction cycle counts.
`define CISE_CYC_SINGLE  5'h01
`define CISE_CYC_LOOP    5'h02
`define CISE_CYC_JUMP    5'h04
`define CISE_CYC_DIV     5'h12
`define CISE_CYC_SFR     5'h01

// Reset values.
`define CISE_RST_WORD    16'h0000
`define CISE_RST_ADDR    23'h00_0000
`define CISE_RST_BLOCK   14'h0000
`define CISE_RST_REMAIN  5'h00

// Packed BCD correction constants.
`define CISE_BCD_NIB_MAX 4'h9
`define CISE_BCD_LO_ADJ  9'h006
`define CISE_BCD_HI_ADJ  9'h060

// Largest quotient magnitudes for the signed divides.
`define CISE_DIV_POS_MAX 32'h0000_7FFF
`define CISE_DIV_NEG_MAX 32'h0000_8000

`endif

// ---- core/cise_pkg.sv ----
// Types shared by the instruction subset executor and its bench.
package cise_pkg;

  // Operation codes accepted on the issue port.
  typedef enum logic [4:0] {
    OP_NOP      = 5'b00000,
    OP_DADJ     = 5'b00001,
    OP_BLOCK    = 5'b00010,
    OP_LOOP_LIT = 5'b00011,
    OP_LOOP_REG = 5'b00100,
    OP_CHANGE   = 5'b00101,
    OP_LEAD     = 5'b00110,
    OP_TRAIL    = 5'b00111,
    OP_JMP_ABS  = 5'b01000,
    OP_JMP_IND  = 5'b01001,
    OP_JMP_LONG = 5'b01010,
    OP_LSR_ONE  = 5'b01011,
    OP_LSR_REG  = 5'b01100,
    OP_LSR_LIT  = 5'b01101,
    OP_INC      = 5'b01110,
    OP_INC2     = 5'b01111,
    OP_DEC      = 5'b10000,
    OP_DEC2     = 5'b10001,
    OP_DIV_S    = 5'b10010,
    OP_DIV_SD   = 5'b10011,
    OP_DIV_U    = 5'b10100,
    OP_DIV_UD   = 5'b10101
  } cise_op_type;

  // Status flags: carry, digit carry, negative, overflow, zero.
  typedef struct packed {
    logic c;
    logic hc;
    logic n;
    logic vf;
    logic z;
  } cise_flags_type;

  // Whole state of the executor.
  typedef struct packed {
    logic [4:0]     remain;
    logic           busy;
    logic           done;
    logic [15:0]    result;
    logic           resultWrite;
    cise_flags_type flags;
    logic [13:0]    blockCnt;
    logic           intBlocked;
    logic           loopStart;
    logic [22:0]    loopEnd;
    logic [15:0]    loopCount;
    logic           jumpPend;
    logic           jumpTake;
    logic [22:0]    jumpTarget;
  } cise_state_type;

endpackage

// ---- core/cise_scan_if.sv ----
// Interface between the executor and its bit scan unit.
`timescale 1ns/1ps
interface cise_scan_if;
  logic [15:0] operand;
  logic [4:0]  leadPos;
  logic [4:0]  trailPos;
  logic [4:0]  changePos;
  logic        leadNone;
  logic        trailNone;
  logic        changeNone;

  modport exec (output operand, input leadPos, input trailPos,
                input changePos, input leadNone, input trailNone,
                input changeNone);
  modport unit (input operand, output leadPos, output trailPos,
                output changePos, output leadNone, output trailNone,
                output changeNone);
endinterface

// ---- core/cise_scan.sv ----
// Bit scan unit: leading one, trailing one and sign change positions.
`timescale 1ns/1ps
module cise_scan
(
  // Operand in, positions out.
  cise_scan_if.unit scan
);

  // Later loop passes overwrite earlier ones, so each loop runs towards
  // the bit that must win the priority.
  always_comb
  begin
    scan.leadPos   = 5'h00;
    scan.trailPos  = 5'h00;
    scan.changePos = 5'h00;
    for (int i = 0; i < 16; i++)
    begin
      if (scan.operand[i])
        scan.leadPos = 5'(16 - i);
    end
    for (int i = 15; i >= 0; i--)
    begin
      if (scan.operand[i])
        scan.trailPos = 5'(i + 1);
    end
    for (int i = 0; i < 15; i++)
    begin
      if (scan.operand[i] != scan.operand[15])
        scan.changePos = 5'(15 - i);
    end
    scan.leadNone   = (scan.operand == 16'h0000);
    scan.trailNone  = (scan.operand == 16'h0000);
    scan.changeNone = (scan.changePos == 5'h00);
  end

endmodule

// ---- core/cise_exec.sv ----
// Executor for a subset of a 16-bit processor core's instruction set.
// Notes on behaviour
// RQ1: Decimal adjust fixes packed BCD low byte in one cycle, carry only.
// RQ2: Interrupt block: 14-bit count holds off interrupts that many cycles.
// RQ3: Loop setup: end is PC plus offset, count literal or register plus one.
// RQ4: Bit-change scan finds first bit from top unlike the sign, one cycle.
// RQ5: Leading-one scan finds first set bit from the top, one cycle.
// RQ6: Trailing-one scan finds first set bit from the bottom, one cycle.
// RQ7: All three jump forms take four cycles and leave flags alone.
// RQ8: Single-position right shift takes one cycle, updates C, N, V and Z.
// RQ9: Register-amount right shift takes one cycle, updates only N and Z.
// RQ10: Literal-amount right shift takes one cycle, updates only N and Z.
// RQ11: Operand from an outside peripheral register costs one extra cycle.
// RQ12: Increment and decrement by one or two, one cycle, all five flags.
// RQ13: All four integer divides run eighteen cycles, update N, Z, C, V.
`timescale 1ns/1ps
`include "cise_defines.svh"
module cise_exec
(
  // Clock and reset.
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // Issue port.
  input  wire logic                  opValid,
  input  wire cise_pkg::cise_op_type opCode,
  input  wire logic                  sfrOperand,
  input  wire logic [15:0]           opA,
  input  wire logic [15:0]           opB,
  input  wire logic [15:0]           opHi,
  input  wire logic [15:0]           imm,
  input  wire logic [22:0]           progCnt,
  // Completion.
  output logic                       busy,
  output logic                       done,
  output logic [15:0]                result,
  output logic                       resultWrite,
  output cise_pkg::cise_flags_type   flags,
  // Interrupt hold-off.
  output logic                       intBlocked,
  // Hardware loop setup.
  output logic                       loopStart,
  output logic [22:0]                loopEnd,
  output logic [15:0]                loopCount,
  // Jump.
  output logic                       jumpTake,
  output logic [22:0]                jumpTarget
);
  import cise_pkg::*;

  cise_state_type st_r;
  cise_state_type st_nxt;
  logic           accept;
  logic [4:0]     cycles;
  logic [16:0]    step;
  logic [16:0]    incSum;
  logic [16:0]    decDif;
  logic [4:0]     nibSum;
  logic [4:0]     nibDif;
  logic [8:0]     bcdLo;
  logic [8:0]     bcdHi;
  logic [4:0]     shiftAmt;
  logic [15:0]    shiftRes;
  logic           divSigned;
  logic [31:0]    dividend;
  logic           dvdNeg;
  logic           dsrNeg;
  logic [31:0]    dvdMag;
  logic [15:0]    dsrMag;
  logic [31:0]    quoMag;
  logic [31:0]    remMag;
  logic [31:0]    quoVal;
  logic           divOver;

  cise_scan_if scanBus ();

  cise_scan u_scan
  (
    .scan (scanBus.unit)
  );

  ////////////////////////////////////////////////////////////////////////
  // Datapath helpers.

  // New work is taken only while the previous instruction has retired.
  assign accept          = opValid && !st_r.busy;
  assign scanBus.operand = opA;

  // Increment and decrement by one or two share one adder each.
  assign step   = (opCode == OP_INC2 || opCode == OP_DEC2) ?
                  17'h0_0002 : 17'h0_0001;
  assign incSum = {1'b0, opA} + step;
  assign decDif = {1'b0, opA} - step;
  assign nibSum = {1'b0, opA[3:0]} + step[4:0];
  assign nibDif = {1'b0, opA[3:0]} - step[4:0];

  // Packed BCD correction uses the carries left by the preceding add.
  assign bcdLo = (opA[3:0] > `CISE_BCD_NIB_MAX || st_r.flags.hc) ?
                 {1'b0, opA[7:0]} + `CISE_BCD_LO_ADJ : {1'b0, opA[7:0]};
  assign bcdHi = (bcdLo[7:4] > `CISE_BCD_NIB_MAX || bcdLo[8] ||
                  st_r.flags.c) ? bcdLo + `CISE_BCD_HI_ADJ : bcdLo;

  // Amounts of sixteen or more shift every bit out.
  assign shiftAmt = (opCode == OP_LSR_REG) ? opB[4:0] : imm[4:0];
  assign shiftRes = opA >> shiftAmt;

  // Divides work on magnitudes; a zero divisor reports overflow.
  assign divSigned = (opCode == OP_DIV_S || opCode == OP_DIV_SD);
  assign dividend  = (opCode == OP_DIV_SD || opCode == OP_DIV_UD) ?
                     {opHi, opA} :
                     (divSigned ? {{16{opA[15]}}, opA} : {16'h0000, opA});
  assign dvdNeg    = divSigned && dividend[31];
  assign dsrNeg    = divSigned && opB[15];
  assign dvdMag    = dvdNeg ? 32'h0000_0000 - dividend : dividend;
  assign dsrMag    = dsrNeg ? 16'h0000 - opB : opB;
  assign quoMag    = (dsrMag == 16'h0000) ? 32'h0000_0000 :
                     dvdMag / {16'h0000, dsrMag};
  assign remMag    = (dsrMag == 16'h0000) ? 32'h0000_0000 :
                     dvdMag % {16'h0000, dsrMag};
  assign quoVal    = (dvdNeg ^ dsrNeg) ? 32'h0000_0000 - quoMag : quoMag;
  assign divOver   = (dsrMag == 16'h0000) ||
                     (divSigned ? (quoMag > ((dvdNeg ^ dsrNeg) ?
                                   `CISE_DIV_NEG_MAX : `CISE_DIV_POS_MAX))
                                : (quoMag[31:16] != 16'h0000));

  // Listed cycle count of the operation being issued.
  always_comb
  begin
    unique case (opCode)
      OP_LOOP_LIT, OP_LOOP_REG:            cycles = `CISE_CYC_LOOP;
      OP_JMP_ABS, OP_JMP_IND, OP_JMP_LONG: cycles = `CISE_CYC_JUMP; // see RQ7
      OP_DIV_S, OP_DIV_SD, OP_DIV_U, OP_DIV_UD:
        cycles = `CISE_CYC_DIV; // see RQ13
      default:                             cycles = `CISE_CYC_SINGLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state. Results, flags and loop registers change on the accepting
  // edge; done and jumpTake mark the edge on which the cycles are spent.
  always_comb
  begin
    st_nxt             = st_r;
    st_nxt.done        = 1'b0;
    st_nxt.resultWrite = 1'b0;
    st_nxt.loopStart   = 1'b0;
    st_nxt.jumpTake    = 1'b0;
    if (st_r.blockCnt != `CISE_RST_BLOCK)
      st_nxt.blockCnt = st_r.blockCnt - 14'h0001; // see RQ2
    if (st_r.busy)
    begin
      st_nxt.remain = st_r.remain - 5'h01;
      if (st_r.remain == 5'h01)
      begin
        st_nxt.done     = 1'b1;
        st_nxt.jumpTake = st_r.jumpPend;
        st_nxt.jumpPend = 1'b0;
      end
    end
    else if (opValid)
    begin
      // Outside peripheral operands cost one more cycle. see RQ11
      st_nxt.remain = cycles - 5'h01 + (sfrOperand ? `CISE_CYC_SFR : 5'h00);
      st_nxt.done   = (st_nxt.remain == `CISE_RST_REMAIN);
      unique case (opCode)
        OP_NOP:
          st_nxt.result = st_r.result;
        OP_DADJ:
        begin
          st_nxt.result      = {opA[15:8], bcdHi[7:0]}; // see RQ1
          st_nxt.resultWrite = 1'b1;
          st_nxt.flags.c     = bcdHi[8] | bcdLo[8] | st_r.flags.c;
        end
        OP_BLOCK:
          st_nxt.blockCnt = imm[13:0]; // see RQ2
        OP_LOOP_LIT, OP_LOOP_REG:
        begin
          // The register form wraps when the register holds all ones.
          st_nxt.loopStart = 1'b1;
          st_nxt.loopEnd   = progCnt + {{7{opB[15]}}, opB}; // see RQ3
          st_nxt.loopCount = (opCode == OP_LOOP_LIT) ?
                             {1'b0, imm[14:0]} + 16'h0001 :
                             opA + 16'h0001; // see RQ3
        end
        OP_CHANGE:
        begin
          st_nxt.result      = {11'h000, scanBus.changePos}; // see RQ4
          st_nxt.resultWrite = 1'b1;
          st_nxt.flags.c     = scanBus.changeNone;
        end
        OP_LEAD:
        begin
          st_nxt.result      = {11'h000, scanBus.leadPos}; // see RQ5
          st_nxt.resultWrite = 1'b1;
          st_nxt.flags.c     = scanBus.leadNone;
        end
        OP_TRAIL:
        begin
          st_nxt.result      = {11'h000, scanBus.trailPos}; // see RQ6
          st_nxt.resultWrite = 1'b1;
          st_nxt.flags.c     = scanBus.trailNone;
        end
        OP_JMP_ABS, OP_JMP_LONG:
        begin
          st_nxt.jumpPend   = 1'b1;
          st_nxt.jumpTarget = {opHi[6:0], opA}; // see RQ7
        end
        OP_JMP_IND:
        begin
          st_nxt.jumpPend   = 1'b1;
          st_nxt.jumpTarget = {7'h00, opA}; // see RQ7
        end
        OP_LSR_ONE:
        begin
          st_nxt.result      = {1'b0, opA[15:1]}; // see RQ8
          st_nxt.resultWrite = 1'b1;
          st_nxt.flags.c     = opA[0];
          st_nxt.flags.n     = 1'b0;
          st_nxt.flags.vf    = 1'b0;
          st_nxt.flags.z     = (opA[15:1] == 15'h0000);
        end
        OP_LSR_REG, OP_LSR_LIT:
        begin
          st_nxt.result      = shiftRes; // see RQ9 see RQ10
          st_nxt.resultWrite = 1'b1;
          st_nxt.flags.n     = shiftRes[15];
          st_nxt.flags.z     = (shiftRes == 16'h0000);
        end
        OP_INC, OP_INC2:
        begin
          st_nxt.result      = incSum[15:0]; // see RQ12
          st_nxt.resultWrite = 1'b1;
          st_nxt.flags.c     = incSum[16];
          st_nxt.flags.hc    = nibSum[4];
          st_nxt.flags.n     = incSum[15];
          st_nxt.flags.vf    = !opA[15] && incSum[15];
          st_nxt.flags.z     = (incSum[15:0] == 16'h0000);
        end
        OP_DEC, OP_DEC2:
        begin
          // Carry and digit carry read as "no borrow" after a subtract.
          st_nxt.result      = decDif[15:0]; // see RQ12
          st_nxt.resultWrite = 1'b1;
          st_nxt.flags.c     = !decDif[16];
          st_nxt.flags.hc    = !nibDif[4];
          st_nxt.flags.n     = decDif[15];
          st_nxt.flags.vf    = opA[15] && !decDif[15];
          st_nxt.flags.z     = (decDif[15:0] == 16'h0000);
        end
        OP_DIV_S, OP_DIV_SD, OP_DIV_U, OP_DIV_UD:
        begin
          st_nxt.result      = quoVal[15:0]; // see RQ13
          st_nxt.resultWrite = 1'b1;
          st_nxt.flags.n     = quoVal[15];
          st_nxt.flags.z     = (quoVal[15:0] == 16'h0000);
          st_nxt.flags.c     = (remMag != 32'h0000_0000);
          st_nxt.flags.vf    = divOver;
        end
      endcase
    end
    st_nxt.busy       = (st_nxt.remain != `CISE_RST_REMAIN);
    st_nxt.intBlocked = (st_nxt.blockCnt != `CISE_RST_BLOCK);
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st_r            <= '0;
      st_r.result     <= `CISE_RST_WORD;
      st_r.loopEnd    <= `CISE_RST_ADDR;
      st_r.jumpTarget <= `CISE_RST_ADDR;
    end
    else
      st_r <= st_nxt;
  end

  assign busy        = st_r.busy;
  assign done        = st_r.done;
  assign result      = st_r.result;
  assign resultWrite = st_r.resultWrite;
  assign flags       = st_r.flags;
  assign intBlocked  = st_r.intBlocked;
  assign loopStart   = st_r.loopStart;
  assign loopEnd     = st_r.loopEnd;
  assign loopCount   = st_r.loopCount;
  assign jumpTake    = st_r.jumpTake;
  assign jumpTarget  = st_r.jumpTarget;

  ////////////////////////////////////////////////////////////////////////
  // Checks on timing and flag effects.

  // A peripheral operand delays done by one cycle, so done is the inverse of it.
  a_daw_carry_only: assert property (@(posedge clk_sys) // see RQ1
    disable iff (!rst_n)
    accept && opCode == OP_DADJ |=> flags.n == $past(flags.n) &&
      flags.z == $past(flags.z) && flags.vf == $past(flags.vf) &&
      flags.hc == $past(flags.hc) && done == !$past(sfrOperand))
    else $error("decimal adjust changed a flag other than carry");

  a_block_loaded: assert property (@(posedge clk_sys) // see RQ2
    disable iff (!rst_n)
    accept && opCode == OP_BLOCK && imm[13:0] == 14'h0002 |=>
      intBlocked ##1 intBlocked ##1 !intBlocked)
    else $error("interrupt block count did not last two cycles");

  a_loop_two_cycles: assert property (@(posedge clk_sys) // see RQ3
    disable iff (!rst_n)
    accept && opCode == OP_LOOP_LIT && !sfrOperand |=>
      loopStart && loopCount == $past(imm[14:0]) + 16'h0001 && !done
      ##1 done)
    else $error("loop setup timing or count wrong");

  a_change_write: assert property (@(posedge clk_sys) // see RQ4
    disable iff (!rst_n)
    accept && opCode == OP_CHANGE |=> resultWrite)
    else $error("bit change scan did not strobe its result");

  a_lead_scan: assert property (@(posedge clk_sys) // see RQ5
    disable iff (!rst_n)
    accept && opCode == OP_LEAD && opA == 16'h0100 && !sfrOperand |=>
      done && result == 16'h0008 && !flags.c)
    else $error("leading one scan result wrong");

  a_jump_four: assert property (@(posedge clk_sys) // see RQ7
    disable iff (!rst_n)
    accept && opCode == OP_JMP_IND && !sfrOperand |=>
      !done [*3] ##1 (done && jumpTake && flags == $past(flags, 4)))
    else $error("jump did not retire after four cycles");

  a_lsr_one_flags: assert property (@(posedge clk_sys) // see RQ8
    disable iff (!rst_n)
    accept && opCode == OP_LSR_ONE |=>
      flags.c == $past(opA[0]) && !flags.n && !flags.vf)
    else $error("single right shift flags wrong");

  a_lsr_multi_flags: assert property (@(posedge clk_sys) // see RQ10
    disable iff (!rst_n)
    accept && opCode == OP_LSR_LIT |=>
      flags.c == $past(flags.c) && flags.vf == $past(flags.vf) &&
      result == $past(opA) >> $past(imm[4:0]))
    else $error("literal right shift touched carry or overflow");

  a_sfr_extra: assert property (@(posedge clk_sys) // see RQ11
    disable iff (!rst_n)
    accept && sfrOperand && opCode == OP_INC |=> !done ##1 done)
    else $error("peripheral operand did not add one cycle");

  a_div_length: assert property (@(posedge clk_sys) // see RQ13
    disable iff (!rst_n)
    accept && opCode == OP_DIV_U && !sfrOperand |-> ##18 done)
    else $error("divide did not retire after eighteen cycles");

endmodule

// ---- sim/cise_exec_bench.sv ----
// Self-checking bench for the instruction subset executor.
`timescale 1ns/1ps
module cise_exec_bench;
  import cise_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // Expected outcome of one accepted instruction.
  typedef struct {
    int          lat;
    int          kind;
    logic [15:0] res;
    logic [4:0]  flg;
    logic [22:0] addr;
    logic [15:0] cnt;
    int          take;
  } cise_note_type;

  logic           clk_sys;
  logic           rst_n;
  logic           opValid;
  cise_op_type    opCode;
  logic           sfrOperand;
  logic [15:0]    opA;
  logic [15:0]    opB;
  logic [15:0]    opHi;
  logic [15:0]    imm;
  logic [22:0]    progCnt;
  logic           busy;
  logic           done;
  logic [15:0]    result;
  logic           resultWrite;
  cise_flags_type flags;
  logic           intBlocked;
  logic           loopStart;
  logic [22:0]    loopEnd;
  logic [15:0]    loopCount;
  logic           jumpTake;
  logic [22:0]    jumpTarget;
  cise_note_type  notes[$];
  cise_note_type  got;
  int             numErrors;
  int             totalChecks;
  int             cyc;
  int             seed;
  int             n;
  logic [31:0]    v;
  logic [15:0]    mRes;
  logic [4:0]     mFlg;
  cise_op_type    ops1[11] = '{OP_INC, OP_INC2, OP_DEC, OP_DEC2, OP_LEAD,
    OP_TRAIL, OP_CHANGE, OP_LSR_ONE, OP_LSR_REG, OP_LSR_LIT, OP_NOP};
  logic [15:0]    bnd[6] = '{16'h7FFF, 16'h8000, 16'hFFFF, 16'h0000,
    16'h000F, 16'h0100};

  cise_exec u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .opValid(opValid),
    .opCode(opCode), .sfrOperand(sfrOperand), .opA(opA), .opB(opB),
    .opHi(opHi), .imm(imm), .progCnt(progCnt), .busy(busy), .done(done),
    .result(result), .resultWrite(resultWrite), .flags(flags),
    .intBlocked(intBlocked), .loopStart(loopStart), .loopEnd(loopEnd),
    .loopCount(loopCount), .jumpTake(jumpTake), .jumpTarget(jumpTarget));

  ////////////////////////////////////////////////////////////////////////
  // Clock, and a cycle count that cuts a hang short.
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      chkVal(32'h0000_0001, 32'h0000_0000, "timeout");
      endSim();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare, verdict and drive tasks.
  task automatic chkVal(input logic [31:0] g, input logic [31:0] e,
                        input string what);
    totalChecks++;
    if (g !== e)
    begin
      numErrors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, g, e);
    end
  endtask

  task automatic endSim;
    $display("Checks %0d, mismatches %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Drives one request, predicts its outcome and notes it; returns on the
  // edge that takes it. The request is held while busy, so it is refused.
  task automatic issue(input cise_op_type op, input logic [15:0] a, b, hi,
                       k, input logic special_function_register);
    cise_note_type nt;
    logic [16:0]   s;
    logic [4:0]    f;
    logic [22:0]   pc;
    int            i;
    int            xs;
    int            ys;
    pc = 23'($random(seed));
    opValid <= 1'b1;
    opCode <= op;
    opA <= a;
    opB <= b;
    opHi <= hi;
    imm <= k;
    sfrOperand <= special_function_register;
    progCnt <= pc;
    nt = '{1, 0, mRes, mFlg, 23'h00_0000, 16'h0000, 0};
    f = mFlg;
    case (op)
      OP_INC, OP_INC2, OP_DEC, OP_DEC2:
      begin
        i = (op == OP_INC || op == OP_DEC) ? 1 : 2;
        s = (op == OP_INC || op == OP_INC2) ? a + 17'(i) : a - 17'(i);
        if (op == OP_INC || op == OP_INC2)
          f = {s[16], 5'(a[3:0]) + 5'(i) > 5'h0F, s[15], ~a[15] & s[15], 1'b0};
        else
          f = {a >= 16'(i), a[3:0] >= 4'(i), s[15], a[15] & ~s[15], 1'b0};
        f[0] = s[15:0] == 16'h0000;
        nt.res = s[15:0];
      end
      OP_DADJ:
      begin
        s = {9'h000, a[7:0]};
        if (s[3:0] > 4'h9 || mFlg[3])
          s = s + 17'h0006;
        if (s[7:4] > 4'h9 || mFlg[4])
          s = s + 17'h0060;
        nt.res = {a[15:8], s[7:0]};
        f[4] = s[8] | mFlg[4];
      end
      OP_LEAD, OP_TRAIL, OP_CHANGE:
      begin
        nt.res = 16'h0000;
        for (i = 0; i < 16; i++)
        begin
          if (op == OP_LEAD && a[i])
            nt.res = 16'(16 - i);
          if (op == OP_TRAIL && a[i] && nt.res == 16'h0000)
            nt.res = 16'(i + 1);
          if (op == OP_CHANGE && i < 15 && a[i] != a[15])
            nt.res = 16'(15 - i);
        end
        f[4] = nt.res == 16'h0000;
      end
      OP_LSR_ONE:
      begin
        nt.res = a >> 1;
        f = {a[0], mFlg[3], 2'b00, a[15:1] == 15'h0000};
      end
      OP_LSR_REG, OP_LSR_LIT:
      begin
        nt.res = a >> ((op == OP_LSR_REG) ? b[4:0] : k[4:0]);
        f[2] = nt.res[15];
        f[0] = nt.res == 16'h0000;
      end
      OP_JMP_ABS, OP_JMP_IND, OP_JMP_LONG:
      begin
        nt.lat = 4;
        nt.kind = 2;
        nt.addr = (op == OP_JMP_IND) ? {7'h00, a} : {hi[6:0], a};
      end
      OP_LOOP_LIT, OP_LOOP_REG:
      begin
        nt.lat = 2;
        nt.kind = 1;
        nt.addr = pc + {{7{b[15]}}, b};
        nt.cnt = (op == OP_LOOP_LIT) ? {1'b0, k[14:0]} + 16'h0001
                                     : a + 16'h0001;
      end
      OP_DIV_S, OP_DIV_SD, OP_DIV_U, OP_DIV_UD:
      begin
        nt.lat = 18;
        xs = (op == OP_DIV_S) ? int'($signed(a)) :
             (op == OP_DIV_U) ? int'(a) : int'({hi, a});
        ys = (op == OP_DIV_S || op == OP_DIV_SD) ? int'($signed(b)) : int'(b);
        nt.res = 16'(xs / ys);
        f = {xs % ys != 0, mFlg[3], nt.res[15], 1'b0, nt.res == 16'h0000};
      end
      default:
        nt.lat = 1;
    endcase
    nt.lat = nt.lat + int'(special_function_register);
    nt.flg = f;
    mRes = nt.res;
    mFlg = f;
    @(negedge clk_sys);
    while (busy === 1'b1)
      @(negedge clk_sys);
    nt.take = cyc; // The request stands in this cycle.
    notes.push_back(nt);
    @(posedge clk_sys);
  endtask

  // Drops the request on the accepting edge, so a block is not taken twice,
  // then counts cycles with interrupts held off.
  task automatic countBlocked(input int e);
    int c;
    c = 0;
    opValid <= 1'b0;
    repeat (12)
    begin
      @(negedge clk_sys);
      if (intBlocked === 1'b1)
        c++;
    end
    chkVal(32'(c), 32'(e), "blocked cycles");
    @(posedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watcher: each done pulse retires the oldest note.
  always @(negedge clk_sys)
  begin
    if (done === 1'b1)
    begin
      chkVal(32'(notes.size() == 0), 32'h0, "unexpected done");
      if (notes.size() != 0)
      begin
        got = notes.pop_front();
        chkVal(32'(cyc - got.take), 32'(got.lat), "cycles");
        chkVal(32'(result), 32'(got.res), "result");
        chkVal(32'(flags), 32'(got.flg), "flags");
        chkVal(32'(jumpTake), 32'(got.kind == 2), "jump pulse");
        if (got.kind == 2)
          chkVal(32'(jumpTarget), 32'(got.addr), "target");
        if (got.kind == 1)
          chkVal({loopEnd, 9'h000}, {got.addr, 9'h000}, "end");
        if (got.kind == 1)
          chkVal(32'(loopCount), 32'(got.cnt), "count");
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    {numErrors, totalChecks, cyc} = '0;
    seed = 86383;
    {opValid, sfrOperand, opA, opB, opHi, imm, progCnt} = '0;
    opCode = OP_NOP;
    mRes = 16'h0000;
    mFlg = 5'h00;
    rst_n = 1'b0;
    repeat (8) @(posedge clk_sys);
    chkVal(32'({busy, done, intBlocked, jumpTake, loopStart, flags, result}),
           32'h0000_0000, "reset state");
    rst_n <= 1'b1;
    @(posedge clk_sys);
    // Random one-cycle work back to back, some with a peripheral operand.
    for (n = 0; n < 60; n++)
    begin
      v = $random(seed);
      issue(ops1[n % 11], v[15:0], v[31:16], 16'h0000, v[31:16], v[7]);
    end
    // Boundary operands for every one-cycle operation except decimal adjust and block.
    for (n = 0; n < 66; n++)
    begin
      v = {16'h0000, bnd[n % 6]};
      issue(ops1[n / 6], v[15:0], 16'h0011, 16'h0000, 16'h0010, 1'b0);
    end
    // Decimal adjust, with carry and digit carry first cleared.
    issue(OP_INC, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 1'b0);
    issue(OP_DADJ, 16'h001A, 16'h0000, 16'h0000, 16'h0000, 1'b0);
    issue(OP_DADJ, 16'h00A3, 16'h0000, 16'h0000, 16'h0000, 1'b0);
    issue(OP_DADJ, 16'h0012, 16'h0000, 16'h0000, 16'h0000, 1'b0);
    // Loops at the count limits, then each jump form; the request after a
    // jump is held while busy and must not be taken early.
    issue(OP_LOOP_LIT, 16'h0000, 16'hFFF0, 16'h0000, 16'hFFFF, 1'b0);
    issue(OP_LOOP_REG, 16'hFFFF, 16'h0123, 16'h0000, 16'h0000, 1'b1);
    issue(OP_JMP_ABS, 16'hBEEF, 16'h0000, 16'h00FF, 16'h0000, 1'b0);
    issue(OP_JMP_IND, 16'h1234, 16'h0000, 16'h0055, 16'h0000, 1'b0);
    issue(OP_JMP_LONG, 16'h4321, 16'h0000, 16'h0041, 16'h0000, 1'b1);
    issue(OP_INC, 16'h7FFF, 16'h0000, 16'h0000, 16'h0000, 1'b0);
    // Each divide form.
    issue(OP_DIV_U, 16'h0064, 16'h0007, 16'h0000, 16'h0000, 1'b0);
    issue(OP_DIV_UD, 16'h0000, 16'h0004, 16'h0001, 16'h0000, 1'b0);
    issue(OP_DIV_S, 16'hFF9C, 16'h0007, 16'h0000, 16'h0000, 1'b0);
    issue(OP_DIV_SD, 16'hFF00, 16'hFFF0, 16'hFFFF, 16'h0000, 1'b1);
    // Interrupt hold-off: upper literal bits ignored, reload, zero count.
    issue(OP_BLOCK, 16'h0000, 16'h0000, 16'h0000, 16'hC005, 1'b0);
    countBlocked(5);
    issue(OP_BLOCK, 16'h0000, 16'h0000, 16'h0000, 16'h0005, 1'b0);
    issue(OP_BLOCK, 16'h0000, 16'h0000, 16'h0000, 16'h0002, 1'b0);
    countBlocked(2);
    issue(OP_BLOCK, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 1'b0);
    countBlocked(0);
    repeat (4) @(posedge clk_sys);
    chkVal(32'(notes.size()), 32'h0000_0000, "notes left");
    endSim();
  end
endmodule
